// ### core/rwc_pkg.sv
package rwc_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [11:0] WD_CTRL_ADDR = 12'h008;
   localparam logic [11:0] WD_WIN_ADDR = 12'h00C;
   localparam logic [11:0] PROTECT_ADDR = 12'h010;
   localparam logic [11:0] STATE_ADDR = 12'h014;
   // ----------------------------------------
   // fields
   // ----------------------------------------
   localparam int CTRL_SWRST_BIT = 0;
   localparam int CTRL_BOOTVEC_BIT = 1;
   localparam int WD_EN_BIT = 0;
   localparam int WD_WEN_BIT = 1;
   localparam int WD_PER_LSB = 2;
   localparam int WD_PER_W = 4;
   localparam int SRC_NUM = 6;
   localparam int SRC_POR = 0;
   localparam int SRC_EXT = 1;
   localparam int SRC_BROWNOUT = 2;
   localparam int SRC_WDOG = 3;
   localparam int SRC_DBG = 4;
   localparam int SRC_SW = 5;
   localparam logic [7:0] PROTECT_KEY = 8'hD8;
   localparam int PROTECT_WIN = 4;
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int LP_TICK_HZ = 1_000;
   localparam int LP_TICK_CYC = CLK_HZ / LP_TICK_HZ;
   localparam int OSC2M_HZ = 2_000_000;
   localparam int OSC2M_CYC = CLK_HZ / OSC2M_HZ;
   localparam int WD_PER_NUM = 11;
   localparam int WD_MIN_MS = 8;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [2:0] {ST_RESET, ST_DELAY, ST_OSC_START, ST_OSC_CAL, ST_SYNC, ST_RUN} rwc_state_t;
endpackage : rwc_pkg

// ### core/rwc_top.sv
// Function
// R1 - hold reset until all sources release
// R2 - tristate pins immediately on reset
// R3 - load vector, init registers, keep SRAM
// R4 - vector zero or boot section start
// R5 - reset asserts without any clock
// R6 - delay, oscillator start, calibration stages
// R7 - new request restarts release sequence
// R8 - sticky source flags, cleared by power-on
// R9 - power-on detector starts and holds reset
// R10 - brownout forced on in erase/debug
// R11 - external pin held low keeps reset
// R12 - watchdog request lasts one-two 2MHz cycles
// R13 - software reset within two cycles
// R14 - cpu blocked until software reset issues
// R15 - debug reset only from debug port
// R16 - watchdog times out without clear
// R17 - eleven periods 8ms to 8s on 1kHz
// R18 - early or late window clear resets
// R19 - watchdog runs in sleep, own clock
// R20 - settings need protection, lock fuse freezes
// R21 - reset selects 2MHz osc, others off
// R22 - release synchronized to system clock
// R23 - every asserting source sets its flag
`timescale 1ns/1ps
`default_nettype none
module rwc_top #(
   parameter int DELAY_CYC = 64,
   parameter int OSC_START_CYC = 32,
   parameter int OSC_CAL_CYC = 32,
   parameter int LP_TICK = rwc_pkg::LP_TICK_CYC
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic por_detect,
   input wire logic ext_reset_n,
   input wire logic brownout_trip,
   input wire logic brownout_enable_fuse,
   input wire logic chip_erase,
   input wire logic dbg_port_enable,
   input wire logic dbg_port_reset_req,
   input wire logic wd_lock_fuse,
   input wire logic watchdog_clear_instruction,
   output logic sys_reset_n,
   output logic pins_tristate,
   output logic cpu_halt,
   output logic [31:0] pc_load_value,
   output logic osc2m_enable,
   output logic other_osc_enable,
   output logic brownout_active
);
   // ----------------------------------------
   // reset request merge
   // ----------------------------------------
   logic [5:0] src_req;
   logic any_req;
   logic wd_req_q;
   logic sw_req_q;
   logic brownout_on;
   // R10 brownout forcing
   assign brownout_on = brownout_enable_fuse | chip_erase | dbg_port_enable;
   // R9 R11 R15 source merge
   assign src_req[rwc_pkg::SRC_POR] = por_detect;
   assign src_req[rwc_pkg::SRC_EXT] = ~ext_reset_n;
   assign src_req[rwc_pkg::SRC_BROWNOUT] = brownout_on & brownout_trip;
   assign src_req[rwc_pkg::SRC_WDOG] = wd_req_q;
   // debug reset has no software path
   assign src_req[rwc_pkg::SRC_DBG] = dbg_port_reset_req;
   assign src_req[rwc_pkg::SRC_SW] = sw_req_q;
   assign any_req = |src_req;
   // internal async reset: bypasses the clock entirely
   logic core_rst_n;
   assign core_rst_n = presetn & ~any_req;
   // ----------------------------------------
   // release sequencer
   // ----------------------------------------
   rwc_pkg::rwc_state_t state_q;
   logic [15:0] cnt_q;
   logic [rwc_pkg::SYNC_STAGES-1:0] sync_q;
   logic cnt_done;
   logic [15:0] stage_len;
   assign stage_len = (state_q == rwc_pkg::ST_DELAY) ? 16'(DELAY_CYC) :
                      (state_q == rwc_pkg::ST_OSC_START) ? 16'(OSC_START_CYC) : 16'(OSC_CAL_CYC);
   assign cnt_done = (cnt_q >= stage_len - 16'h0001);
   // R1 R5 R7 async hold and restart
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         state_q <= rwc_pkg::ST_RESET;
         cnt_q <= 16'h0000;
      end
      else
      begin
         cnt_q <= cnt_done ? 16'h0000 : cnt_q + 16'h0001;
         // R6 ordered stages
         case (state_q)
            rwc_pkg::ST_RESET: begin state_q <= rwc_pkg::ST_DELAY; cnt_q <= 16'h0000; end
            rwc_pkg::ST_DELAY: if (cnt_done) state_q <= rwc_pkg::ST_OSC_START;
            rwc_pkg::ST_OSC_START: if (cnt_done) state_q <= rwc_pkg::ST_OSC_CAL;
            rwc_pkg::ST_OSC_CAL: if (cnt_done) state_q <= rwc_pkg::ST_SYNC;
            rwc_pkg::ST_SYNC: state_q <= rwc_pkg::ST_RUN;
            rwc_pkg::ST_RUN: cnt_q <= 16'h0000;
            default: state_q <= rwc_pkg::ST_RESET;
         endcase
      end
   end
   // R22 release synchronizer
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
         sync_q <= '0;
      else
         sync_q <= {sync_q[rwc_pkg::SYNC_STAGES-2:0], (state_q == rwc_pkg::ST_SYNC) | (state_q == rwc_pkg::ST_RUN)};
   end
   logic run;
   assign run = sync_q[rwc_pkg::SYNC_STAGES-1];
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [5:0] flags_q;
   logic boot_vec_q;
   logic wd_en_q, wd_wen_q;
   logic [3:0] wd_per_q, wd_win_q;
   logic [2:0] prot_cnt_q;
   logic wr_acc, rd_acc, prot_open, wd_cfg_ok;
   assign wr_acc = psel & penable & pwrite & run;
   assign rd_acc = psel & penable & ~pwrite;
   assign prot_open = (prot_cnt_q != 3'h0);
   // R20 protection and lock
   assign wd_cfg_ok = prot_open & ~wd_lock_fuse;
   logic wr_ctrl, wr_wd, wr_win, wr_prot;
   assign wr_ctrl = wr_acc & (paddr == rwc_pkg::CTRL_ADDR);
   assign wr_wd = wr_acc & (paddr == rwc_pkg::WD_CTRL_ADDR) & wd_cfg_ok;
   assign wr_win = wr_acc & (paddr == rwc_pkg::WD_WIN_ADDR) & wd_cfg_ok;
   assign wr_prot = wr_acc & (paddr == rwc_pkg::PROTECT_ADDR) & (pwdata[7:0] == rwc_pkg::PROTECT_KEY);
   // R8 R23 sticky flags, cleared only by presetn or power-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_q <= 6'h00;
      else if (por_detect)
         flags_q <= src_req;
      else
         flags_q <= flags_q | src_req;
   end
   // R3 config registers return to initial values
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         boot_vec_q <= 1'b0;
         wd_en_q <= 1'b0;
         wd_wen_q <= 1'b0;
         wd_per_q <= 4'h0;
         wd_win_q <= 4'h0;
         prot_cnt_q <= 3'h0;
      end
      else
      begin
         prot_cnt_q <= wr_prot ? 3'(rwc_pkg::PROTECT_WIN) : (prot_open ? prot_cnt_q - 3'h1 : 3'h0);
         if (wr_ctrl)
            boot_vec_q <= pwdata[rwc_pkg::CTRL_BOOTVEC_BIT];
         if (wr_wd)
         begin
            wd_en_q <= pwdata[rwc_pkg::WD_EN_BIT];
            wd_wen_q <= pwdata[rwc_pkg::WD_WEN_BIT];
            wd_per_q <= pwdata[rwc_pkg::WD_PER_LSB +: rwc_pkg::WD_PER_W];
         end
         if (wr_win)
            wd_win_q <= pwdata[3:0];
      end
   end
   // R13 R14 software reset within two cycles
   logic sw_wr;
   assign sw_wr = wr_ctrl & pwdata[rwc_pkg::CTRL_SWRST_BIT];
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sw_req_q <= 1'b0;
      else
         sw_req_q <= sw_wr;
   end
   // ----------------------------------------
   // supervision timer
   // ----------------------------------------
   // R17 period index to ms, doubling from 8
   function automatic logic [13:0] per_ms(input logic [3:0] idx);
      logic [3:0] i;
      i = (idx >= 4'(rwc_pkg::WD_PER_NUM)) ? 4'(rwc_pkg::WD_PER_NUM - 1) : idx;
      per_ms = 14'(rwc_pkg::WD_MIN_MS) << i;
   endfunction : per_ms
   logic [16:0] tick_cnt_q;
   logic tick;
   logic [13:0] wd_cnt_q;
   logic [5:0] wd_pulse_q;
   assign tick = (tick_cnt_q == 17'(LP_TICK - 1));
   logic wd_timeout, wd_early, wd_fire;
   assign wd_timeout = wd_en_q & tick & (wd_cnt_q >= per_ms(wd_per_q) - 14'h0001);
   // R18 early clear in window mode
   assign wd_early = wd_en_q & wd_wen_q & watchdog_clear_instruction & (wd_cnt_q < per_ms(wd_win_q));
   assign wd_fire = wd_timeout | wd_early;
   // R16 R19 free-running on own tick, independent of cpu halt
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         tick_cnt_q <= 17'h0_0000;
         wd_cnt_q <= 14'h0000;
      end
      else
      begin
         tick_cnt_q <= tick ? 17'h0_0000 : tick_cnt_q + 17'h0_0001;
         if (!wd_en_q || watchdog_clear_instruction)
            wd_cnt_q <= 14'h0000;
         else if (tick)
            wd_cnt_q <= wd_cnt_q + 14'h0001;
      end
   end
   // R12 pulse of one 2MHz period, stretched past reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wd_req_q <= 1'b0;
         wd_pulse_q <= 6'h00;
      end
      else if (wd_fire && !wd_req_q)
      begin
         wd_req_q <= 1'b1;
         wd_pulse_q <= 6'(rwc_pkg::OSC2M_CYC - 1);
      end
      else if (wd_pulse_q != 6'h00)
         wd_pulse_q <= wd_pulse_q - 6'h01;
      else
         wd_req_q <= 1'b0;
   end
   // ----------------------------------------
   // bus read and outputs
   // ----------------------------------------
   logic [31:0] rd_mux;
   logic addr_ok;
   assign addr_ok = (paddr <= rwc_pkg::STATE_ADDR) & (paddr[1:0] == 2'b00);
   assign rd_mux = (paddr == rwc_pkg::CTRL_ADDR) ? {30'h0, boot_vec_q, 1'b0} :
                   (paddr == rwc_pkg::STATUS_ADDR) ? {26'h0, flags_q} :
                   (paddr == rwc_pkg::WD_CTRL_ADDR) ? {26'h0, wd_per_q, wd_wen_q, wd_en_q} :
                   (paddr == rwc_pkg::WD_WIN_ADDR) ? {28'h0, wd_win_q} :
                   (paddr == rwc_pkg::PROTECT_ADDR) ? {31'h0, prot_open} :
                   (paddr == rwc_pkg::STATE_ADDR) ? {29'h0, state_q} : 32'h0000_0000;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_ok;
         if (psel && !penable && !pwrite)
            prdata <= rd_mux;
      end
   end
   // R2 R5 outputs forced to their reset values asynchronously by any request
   always_ff @(posedge pclk or negedge core_rst_n)
   begin
      if (!core_rst_n)
      begin
         sys_reset_n <= 1'b0;
         pins_tristate <= 1'b1;
         cpu_halt <= 1'b1;
         pc_load_value <= rwc_pkg::RESET_VECTOR;
         osc2m_enable <= 1'b0;
         other_osc_enable <= 1'b0;
         brownout_active <= 1'b0;
      end
      else
      begin
         sys_reset_n <= run;
         pins_tristate <= ~run;
         // R14 block cpu once swreset written
         cpu_halt <= ~run | sw_wr | sw_req_q;
         // R4 vector relocation
         pc_load_value <= boot_vec_q ? 32'h0000_0000 | 32'(1) << 31 : rwc_pkg::RESET_VECTOR;
         // R21 only 2MHz after reset
         osc2m_enable <= (state_q != rwc_pkg::ST_RESET);
         other_osc_enable <= 1'b0;
         brownout_active <= brownout_on;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_SW_RESET: assert property (@(posedge pclk) disable iff (!presetn) sw_wr |-> ##[1:2] !core_rst_n) // R13
      else $error("software reset not issued in time");
   AST_SW_HALT: assert property (@(posedge pclk) disable iff (!presetn) sw_wr |=> cpu_halt) // R14
      else $error("cpu not blocked after software reset");
   AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn) (|src_req && !por_detect) |=> (&(flags_q | ~$past(src_req)))) // R23
      else $error("source flag not set");
   AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) $past(any_req) |-> !sys_reset_n) // R1
      else $error("reset released while request active");
   AST_SEQ: assert property (@(posedge pclk) disable iff (!core_rst_n) (state_q == rwc_pkg::ST_DELAY) |-> !sys_reset_n) // R6
      else $error("running before sequence done");
   AST_EXT: assert property (@(posedge pclk) disable iff (!presetn) !ext_reset_n |-> (state_q == rwc_pkg::ST_RESET)) // R11
      else $error("external reset not held");
   AST_WD_PULSE: assert property (@(posedge pclk) disable iff (!presetn) $rose(wd_req_q) |-> wd_req_q [*8]) // R12
      else $error("watchdog request too short");
   AST_BROWNOUT: assert property (@(posedge pclk) disable iff (!core_rst_n) (dbg_port_enable || chip_erase) |=> brownout_active) // R10
      else $error("brownout not forced on");
   AST_LOCK: assert property (@(posedge pclk) disable iff (!core_rst_n) wd_lock_fuse |=> $stable(wd_per_q)) // R20
      else $error("locked watchdog changed");
endmodule : rwc_top
`default_nettype wire

// ### verif/rwc_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// reset pin driver and debug programmer
// ----------------------------------------
module rwc_partner (
   input wire logic pclk,
   input wire logic hold_pin,
   input wire logic dbg_on,
   input wire logic dbg_rst,
   output logic ext_reset_n,
   output logic dbg_port_enable,
   output logic dbg_port_reset_req
);
   initial
   begin
      ext_reset_n = 1'b1;
      dbg_port_enable = 1'b0;
      dbg_port_reset_req = 1'b0;
   end
   always @(posedge pclk)
   begin
      ext_reset_n <= ~hold_pin;
      dbg_port_enable <= dbg_on | dbg_rst;
      dbg_port_reset_req <= dbg_rst;
   end
endmodule : rwc_partner
`default_nettype wire

// ### verif/tb_rwc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rwc_top;
   logic pclk, presetn, psel, penable, pwrite, por_detect, brownout_trip, brownout_enable_fuse, chip_erase, er;
   logic wd_lock_fuse, watchdog_clear_instruction, pin_hold, dbg_on, dbg_rst, ext_reset_n, dbg_port_enable;
   logic dbg_port_reset_req, pready, pslverr, sys_reset_n, pins_tristate, cpu_halt, osc2m_enable;
   logic other_osc_enable, brownout_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, pc_load_value;
   logic [3:0] row_req [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
   logic [31:0] row_flag [4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004, 32'h0000_0010};
   logic [31:0] key = {24'h00_0000, rwc_pkg::PROTECT_KEY};
   int n_errors = 0;
   int n_tests = 0;
   int c;
   // ----------------------------------------
   // design and partner
   // ----------------------------------------
   rwc_top #(.DELAY_CYC(4), .OSC_START_CYC(4), .OSC_CAL_CYC(4), .LP_TICK(10)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_detect(por_detect),
      .ext_reset_n(ext_reset_n), .brownout_trip(brownout_trip), .brownout_enable_fuse(brownout_enable_fuse),
      .chip_erase(chip_erase), .dbg_port_enable(dbg_port_enable), .dbg_port_reset_req(dbg_port_reset_req),
      .wd_lock_fuse(wd_lock_fuse), .watchdog_clear_instruction(watchdog_clear_instruction),
      .sys_reset_n(sys_reset_n), .pins_tristate(pins_tristate), .cpu_halt(cpu_halt),
      .pc_load_value(pc_load_value), .osc2m_enable(osc2m_enable), .other_osc_enable(other_osc_enable),
      .brownout_active(brownout_active));
   rwc_partner partner (.pclk(pclk), .hold_pin(pin_hold), .dbg_on(dbg_on), .dbg_rst(dbg_rst),
      .ext_reset_n(ext_reset_n), .dbg_port_enable(dbg_port_enable), .dbg_port_reset_req(dbg_port_reset_req));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic stop_test;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // keep holds psel for a back-to-back setup; otherwise one idle edge passes
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic keep);
      int k;
      // penable is already low here; psel may still stand from a kept transfer
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      penable <= 1'b0;
      if (!keep)
      begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb
   task automatic wait_run(output int n);
      n = 0;
      do
      begin
         @(posedge pclk);
         #1;
         n++;
      end
      while (sys_reset_n !== 1'b1 && n < 300);
   endtask : wait_run
   task automatic src(input logic [3:0] v);
      por_detect <= v[0];
      pin_hold <= v[1];
      brownout_trip <= v[2];
      dbg_rst <= v[3];
   endtask : src
   // ----------------------------------------
   // clock, watchdog, main sequence
   // ----------------------------------------
   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial
   begin
      #400_000;
      n_errors++;
      stop_test();
   end
   initial
   begin
      {presetn, psel, penable, pwrite, por_detect, brownout_trip, chip_erase, wd_lock_fuse} = 8'h00;
      {watchdog_clear_instruction, pin_hold, dbg_on, dbg_rst} = 4'h0;
      brownout_enable_fuse = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      wait_run(c);
      for (int i = 0; i < 4; i++)
      begin
         src(row_req[i]);
         @(posedge pclk);
         #2;
         chk("reset outputs", 32'h3, {29'h0, sys_reset_n, pins_tristate, cpu_halt});
         repeat (4) @(posedge pclk);
         chk("held", 32'h0, {31'h0, sys_reset_n});
         src(4'h0);
         wait_run(c);
         chk("release stages", 32'h1, {31'h0, c >= 14 && c < 300});
         apb(rwc_pkg::STATUS_ADDR, 1'b0, 32'h0, 1'b0);
         chk("status flag", row_flag[i], rd & row_flag[i]);
      end
      chk("vector", 32'h0, pc_load_value);
      chk("oscillators", 32'h2, {30'h0, osc2m_enable, other_osc_enable});
      brownout_enable_fuse <= 1'b0;
      for (int j = 0; j < 4; j++)
      begin
         {chip_erase, dbg_on} <= j[1:0];
         repeat (4) @(posedge pclk);
         chk("brownout forced", {31'h0, j != 0}, {31'h0, brownout_active});
      end
      {brownout_enable_fuse, chip_erase, dbg_on} <= 3'b100;
      src(4'h2);
      repeat (4) @(posedge pclk);
      src(4'h0);
      repeat (8) @(posedge pclk);
      src(4'h2);
      repeat (4) @(posedge pclk);
      src(4'h0);
      wait_run(c);
      chk("restart", 32'h1, {31'h0, c >= 14});
      apb(12'h018, 1'b0, 32'h0, 1'b0);
      chk("unmapped pslverr", 32'h1, {31'h0, er});
      apb(rwc_pkg::CTRL_ADDR, 1'b1, 32'h0000_0002, 1'b0);
      @(posedge pclk);
      chk("boot vector", 32'h8000_0000, pc_load_value);
      apb(rwc_pkg::CTRL_ADDR, 1'b1, 32'h0000_0001, 1'b0);
      @(posedge pclk);
      #1;
      chk("sw reset", 32'h1, {30'h0, sys_reset_n, cpu_halt});
      wait_run(c);
      apb(rwc_pkg::STATUS_ADDR, 1'b0, 32'h0, 1'b0);
      chk("sw flag", 32'h0000_0020, rd & 32'h0000_0020);
      wd_lock_fuse <= 1'b1;
      apb(rwc_pkg::PROTECT_ADDR, 1'b1, key, 1'b1);
      apb(rwc_pkg::WD_CTRL_ADDR, 1'b1, 32'h0000_0001, 1'b0);
      wd_lock_fuse <= 1'b0;
      apb(rwc_pkg::WD_CTRL_ADDR, 1'b1, 32'h0000_0001, 1'b0);
      apb(rwc_pkg::WD_CTRL_ADDR, 1'b0, 32'h0, 1'b0);
      chk("wd locked", 32'h0, rd & 32'h0000_0001);
      apb(rwc_pkg::PROTECT_ADDR, 1'b1, key, 1'b1);
      apb(rwc_pkg::WD_CTRL_ADDR, 1'b1, 32'h0000_0001, 1'b0);
      apb(rwc_pkg::WD_CTRL_ADDR, 1'b0, 32'h0, 1'b0);
      chk("wd enabled", 32'h1, rd & 32'h0000_0001);
      repeat (5)
      begin
         repeat (40) @(posedge pclk);
         watchdog_clear_instruction <= 1'b1;
         @(posedge pclk);
         watchdog_clear_instruction <= 1'b0;
      end
      chk("wd cleared", 32'h1, {31'h0, sys_reset_n});
      c = 0;
      while (sys_reset_n === 1'b1 && c < 200)
      begin
         @(posedge pclk);
         c++;
      end
      // 8 ticks of 10 cycles, tick phase unknown
      chk("wd timeout", 32'h1, {31'h0, c >= 60 && c <= 110});
      wait_run(c);
      chk("wd hold", 32'h1, {31'h0, c >= 30});
      apb(rwc_pkg::STATUS_ADDR, 1'b0, 32'h0, 1'b0);
      chk("wd flag", 32'h0000_0008, rd & 32'h0000_0008);
      stop_test();
   end
endmodule : tb_rwc_top
`default_nettype wire
